// >>> src/dsa_pkg.sv
package dsa_pkg;

   // array geometry
   localparam int NUM_BANKS = 8;
   localparam int BANK_W    = 3;
   localparam int ROW_W     = 13;
   localparam int COL_W     = 10;
   localparam int AP_BIT    = 10;
   localparam int DQ_W      = 16;

   // burst and latency figures
   localparam int BL_SHORT    = 4;
   localparam int BL_LONG     = 8;
   localparam int AL_MAX_EXT  = 6;
   localparam int AL_MAX_AUTO = 5;
   localparam int WL_OFFSET   = 1;
   localparam int CL_MIN      = 2;
   localparam logic [2:0] BEAT_LAST_S = 3'(BL_SHORT - 1);
   localparam logic [2:0] BEAT_LAST_L = 3'(BL_LONG - 1);

   // mode settings handed in from the register side
   typedef struct packed {
      logic       bl8;
      logic       interleave;
      logic [2:0] additive_latency;
      logic [2:0] cas_latency;
   } dsa_cfg_t;

   localparam dsa_cfg_t CFG_RST = '{
      bl8: 1'b0, interleave: 1'b0,
      additive_latency: 3'h0, cas_latency: 3'h5};

   // command pins as sampled at the clock crossing
   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] bank_select;
      logic [ROW_W-1:0]  addr;
   } dsa_cmd_t;

   // power states, gray along on -> active pd -> precharge pd -> self
   typedef enum logic [1:0] {
      PWR_ON       = 2'h0,
      PWR_ACT_PD   = 2'h1,
      PWR_PRE_PD   = 2'h3,
      PWR_SELF_REF = 2'h2
   } dsa_pwr_t;

   typedef struct packed {
      logic [NUM_BANKS-1:0] open_banks;
      dsa_pwr_t             pwr;
      logic                 col_reject;
      logic [3:0]           ref_count;
   } dsa_stat_t;

   typedef enum logic [2:0] {
      OP_NOP, OP_ACT, OP_PRE, OP_RD, OP_WR, OP_REF
   } dsa_op_t;

   // chip select high masks every command
   function automatic dsa_op_t dsa_decode(input dsa_cmd_t c);
      dsa_op_t op;
      op = OP_NOP;
      if (!c.cs_n)
      begin
         case ({c.ras_n, c.cas_n, c.we_n})
            3'h3:    op = OP_ACT;
            3'h2:    op = OP_PRE;
            3'h5:    op = OP_RD;
            3'h4:    op = OP_WR;
            3'h1:    op = OP_REF;
            default: op = OP_NOP;
         endcase
      end
      return op;
   endfunction

   // burst order inside the 4- or 8-word block
   function automatic logic [2:0] dsa_burst_col(input logic [2:0] start,
                                                input logic [2:0] idx,
                                                input logic       bl8,
                                                input logic       il);
      logic [2:0] c;
      if (il)
         c = bl8 ? (start ^ idx) : {start[2], start[1:0] ^ idx[1:0]};
      else
         c = bl8 ? 3'(start + idx)
                 : {start[2], 2'(start[1:0] + idx[1:0])};
      return c;
   endfunction

endpackage

// >>> src/dsa_word_sync.sv
module dsa_word_sync #(
   parameter int         W       = 8,
   parameter logic [W-1:0] RST_VAL = '0
)(
   // source side
   input  logic         src_clk_i,
   input  logic         src_rst_i,
   input  logic [W-1:0] src_data_i,
   // destination side
   input  logic         dst_clk_i,
   input  logic         dst_rst_i,
   output logic [W-1:0] dst_data_o
);

   logic         req_q, req_d;
   logic [W-1:0] hold_q, hold_d;
   logic         ack_m_q, ack_s_q;
   logic         req_m_q, req_s_q;
   logic         ack_q, ack_d;
   logic [W-1:0] data_q, data_d;

   // source relaunches only after the last word was acknowledged,
   // so hold_q is stable whenever the far side samples it
   always_comb
   begin
      req_d  = req_q;
      hold_d = hold_q;
      if (ack_s_q == req_q)
      begin
         hold_d = src_data_i;
         req_d  = ~req_q;
      end
   end

   always_ff @(posedge src_clk_i)
   begin
      if (src_rst_i)
      begin
         req_q   <= 1'b0;
         hold_q  <= RST_VAL;
         ack_m_q <= 1'b0;
         ack_s_q <= 1'b0;
      end
      else
      begin
         req_q   <= req_d;
         hold_q  <= hold_d;
         ack_m_q <= ack_q;
         ack_s_q <= ack_m_q;
      end
   end

   // destination takes the word when the synced toggle differs
   always_comb
   begin
      ack_d  = ack_q;
      data_d = data_q;
      if (req_s_q != ack_q)
      begin
         data_d = hold_q;
         ack_d  = req_s_q;
      end
   end

   always_ff @(posedge dst_clk_i)
   begin
      if (dst_rst_i)
      begin
         req_m_q <= 1'b0;
         req_s_q <= 1'b0;
         ack_q   <= 1'b0;
         data_q  <= RST_VAL;
      end
      else
      begin
         req_m_q <= req_q;
         req_s_q <= req_m_q;
         ack_q   <= ack_d;
         data_q  <= data_d;
      end
   end

   assign dst_data_o = data_q;

endmodule

// >>> src/dsa_access_core.sv
// What this block does
// RQ1 - commands and addresses are sampled on the rising link clock edge
// RQ2 - data is timed by strobes: device drives on reads, controller on writes
// RQ3 - controller multiplexes row then column address, with bank select
// RQ4 - column commands only to an activated bank; others are refused
// RQ5 - bursts of 4 or 8 beats, sequential or interleaved order
// RQ6 - auto precharge closes the row once its burst has finished
// RQ7 - write latency is read latency minus one cycle
// RQ8 - posted column commands wait an additive latency of 0 to 6
// RQ9 - eight banks each keep their own open row concurrently
// RQ10 - correctly spaced bursts follow one another without a gap
// RQ11 - power-down entered with banks precharged or still active
// RQ12 - auto refresh commands and a self refresh state are supported
// RQ13 - controller avoids self refresh above 95 degrees case temperature; the block has no temperature input and never checks it
// RQ14 - chip select sampled high masks every command
// RQ15 - row low, column high: write select picks activate or precharge
// RQ16 - low ten address bits give column, bit 10 asks auto precharge
// RQ17 - clock enable low freezes outputs and burst address next cycle
module dsa_access_core #(
   parameter int AL_MAX    = dsa_pkg::AL_MAX_EXT,
   parameter int ROW_IDX_W = 1,
   parameter int COL_IDX_W = 4
)(
   // register-side clock and reset
   input  logic                           ref_clk_i,
   input  logic                           srst_i,
   // configuration in, status out
   input  dsa_pkg::dsa_cfg_t              cfg_i,
   output dsa_pkg::dsa_stat_t             stat_o,
   // link clock, enable and command
   input  logic                           lnk_clk_i,
   input  logic                           cke_i,
   input  dsa_pkg::dsa_cmd_t              cmd_i,
   // link data and strobe, split into in, out, enable
   input  logic [dsa_pkg::DQ_W-1:0]       dq_i,
   output logic [dsa_pkg::DQ_W-1:0]       dq_o,
   output logic                           dq_oe_o,
   input  logic                           dqs_i,
   output logic                           dqs_o,
   output logic                           dqs_oe_o
);
   import dsa_pkg::*;

   localparam int MEM_AW = BANK_W + ROW_IDX_W + COL_IDX_W;
   localparam int MEM_D  = 1 << MEM_AW;
   localparam logic [2:0] AL_LIM = 3'(AL_MAX);
   localparam logic [2:0] CL_LIM = 3'(CL_MIN);

   // refuse sizes the counters and memory index cannot hold
   if (AL_MAX < 0 || AL_MAX > AL_MAX_EXT || COL_IDX_W < 3 ||
       COL_IDX_W > COL_W || ROW_IDX_W < 1 || ROW_IDX_W > ROW_W)
   begin : g_bad_param
      $error("dsa_access_core: unsupported parameter value");
   end

   // register-side reset carried over into the link domain
   logic rst_meta_q, rst_lnk_q;
   always_ff @(posedge lnk_clk_i)
   begin
      rst_meta_q <= srst_i;
      rst_lnk_q  <= rst_meta_q;
   end

   // settings cross by handshake, status goes back the same way
   dsa_cfg_t  cfg_l;
   dsa_stat_t stat_l;

   dsa_word_sync #(.W($bits(dsa_cfg_t)), .RST_VAL(CFG_RST)) u_cfg_sync (
      .src_clk_i  (ref_clk_i),
      .src_rst_i  (srst_i),
      .src_data_i (cfg_i),
      .dst_clk_i  (lnk_clk_i),
      .dst_rst_i  (rst_lnk_q),
      .dst_data_o (cfg_l)
   );

   dsa_word_sync #(.W($bits(dsa_stat_t)), .RST_VAL('0)) u_stat_sync (
      .src_clk_i  (lnk_clk_i),
      .src_rst_i  (rst_lnk_q),
      .src_data_i (stat_l),
      .dst_clk_i  (ref_clk_i),
      .dst_rst_i  (srst_i),
      .dst_data_o (stat_o)
   );

   // state of both groups
   logic [NUM_BANKS-1:0] open_q, open_d;
   logic [ROW_IDX_W-1:0] row_q [NUM_BANKS];
   logic [ROW_IDX_W-1:0] row_d [NUM_BANKS];
   dsa_pwr_t             pwr_q, pwr_d;
   logic                 rej_q, rej_d;
   logic [3:0]           refc_q, refc_d;
   logic                 cke_q, dqs_prev_q;
   logic                 pend_v_q, pend_v_d, pend_wr_q, pend_wr_d;
   logic                 pend_ap_q, pend_ap_d;
   logic [BANK_W-1:0]    pend_bank_q, pend_bank_d;
   logic [COL_W-1:0]     pend_col_q, pend_col_d;
   logic [3:0]           pend_cnt_q, pend_cnt_d;
   logic                 cur_v_q, cur_v_d, cur_wr_q, cur_wr_d;
   logic                 cur_ap_q, cur_ap_d, cur_bl8_q, cur_bl8_d;
   logic                 cur_il_q, cur_il_d;
   logic [BANK_W-1:0]    cur_bank_q, cur_bank_d;
   logic [COL_W-1:0]     cur_col_q, cur_col_d;
   logic [2:0]           beat_q, beat_d;
   logic [DQ_W-1:0]      dq_q, dq_d;
   logic                 dq_oe_q, dq_oe_d, dqs_q, dqs_d;
   logic                 dqs_oe_q, dqs_oe_d;
   logic [DQ_W-1:0]      mem_q [MEM_D];

   // decode and derived terms
   dsa_op_t              op;
   logic                 awake, col_w, hit, busy, frozen;
   logic                 fire, last, ap_close, mem_we;
   logic [2:0]           al_eff, cl_eff;
   logic [3:0]           rd_lat, wr_lat;
   logic [MEM_AW-1:0]    mem_a;

   // commands count only while clocked and awake, save a refresh as clock enable falls; the link clock
   // edge is the true/complement crossing
   always_comb
   begin
      op     = dsa_decode(cmd_i);                      // [RQ14]
      awake  = cke_i && cke_q && pwr_q == PWR_ON;      // [RQ1]
      col_w  = awake && (op == OP_RD || op == OP_WR);
      hit    = open_q[cmd_i.bank_select];
      busy   = pend_v_q || cur_v_q;
      frozen = !cke_q;                                 // [RQ17]
      al_eff = (cfg_l.additive_latency > AL_LIM) ? AL_LIM
                                                 : cfg_l.additive_latency;
      cl_eff = (cfg_l.cas_latency < CL_LIM) ? CL_LIM : cfg_l.cas_latency;
      rd_lat = 4'({1'b0, al_eff} + {1'b0, cl_eff});    // [RQ8]
      wr_lat = rd_lat - 4'(WL_OFFSET);                 // [RQ7]
      fire   = pend_v_q && pend_cnt_q == 4'h1 && !frozen;
      last   = cur_v_q &&
               beat_q == (cur_bl8_q ? BEAT_LAST_L : BEAT_LAST_S); // [RQ5]
      ap_close = last && cur_ap_q && !frozen;
      mem_a  = {cur_bank_q, row_q[cur_bank_q],
                cur_col_q[COL_IDX_W-1:3],
                dsa_burst_col(cur_col_q[2:0], beat_q,
                              cur_bl8_q, cur_il_q)};   // [RQ5]
      mem_we = !frozen && cur_v_q && cur_wr_q &&
               dqs_i != dqs_prev_q;                    // [RQ2]
   end

   // bank, power and refresh bookkeeping
   always_comb
   begin
      open_d = open_q;
      row_d  = row_q;
      pwr_d  = pwr_q;
      rej_d  = rej_q;
      refc_d = refc_q;
      if (ap_close)
         open_d[cur_bank_q] = 1'b0;                    // [RQ6]
      if (awake)
      begin
         case (op)
            OP_ACT:
            begin
               open_d[cmd_i.bank_select] = 1'b1;       // [RQ9] [RQ15]
               row_d[cmd_i.bank_select] =
                  cmd_i.addr[ROW_IDX_W-1:0];           // [RQ3]
            end
            OP_PRE:  open_d[cmd_i.bank_select] = 1'b0; // [RQ15]
            OP_REF:
               if (open_q == '0 && !busy)
                  refc_d = refc_q + 4'h1;              // [RQ12]
            OP_RD, OP_WR:
               if (!hit)
                  rej_d = 1'b1;                        // [RQ4]
            default: ;
         endcase
      end
      // entry on the falling clock enable, exit when it returns
      case (pwr_q)
         PWR_ON:
            if (cke_q && !cke_i)
            begin
               if (op == OP_REF && open_q == '0)
                  pwr_d = PWR_SELF_REF;                // [RQ12]
               else if (open_q == '0)
                  pwr_d = PWR_PRE_PD;                  // [RQ11]
               else
                  pwr_d = PWR_ACT_PD;                  // [RQ11]
            end
         PWR_ACT_PD, PWR_PRE_PD, PWR_SELF_REF:
            if (cke_i)
               pwr_d = PWR_ON;
         default: pwr_d = PWR_ON;
      endcase
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (rst_lnk_q)
      begin
         open_q     <= '0;
         pwr_q      <= PWR_ON;
         rej_q      <= 1'b0;
         refc_q     <= 4'h0;
         cke_q      <= 1'b0;
         dqs_prev_q <= 1'b0;
         for (int i = 0; i < NUM_BANKS; i++)
            row_q[i] <= '0;
      end
      else
      begin
         open_q     <= open_d;
         row_q      <= row_d;
         pwr_q      <= pwr_d;
         rej_q      <= rej_d;
         refc_q     <= refc_d;
         cke_q      <= cke_i;
         dqs_prev_q <= dqs_i;
      end
   end

   // posted command waits out its latency, then becomes the burst;
   // a new one may fire on the last beat so data runs gapless
   always_comb
   begin
      pend_v_d = pend_v_q;   pend_wr_d = pend_wr_q;  pend_ap_d = pend_ap_q;
      pend_bank_d = pend_bank_q;  pend_col_d = pend_col_q;
      pend_cnt_d = pend_cnt_q;
      cur_v_d = cur_v_q;     cur_wr_d = cur_wr_q;    cur_ap_d = cur_ap_q;
      cur_bl8_d = cur_bl8_q; cur_il_d = cur_il_q;
      cur_bank_d = cur_bank_q;    cur_col_d = cur_col_q;
      beat_d = beat_q;
      dq_d = dq_q;  dq_oe_d = dq_oe_q;  dqs_d = dqs_q;  dqs_oe_d = dqs_oe_q;
      if (!frozen)
      begin
         if (pend_v_q)
            pend_cnt_d = pend_cnt_q - 4'h1;
         if (cur_v_q)
            beat_d = beat_q + 3'h1;
         if (last)
            cur_v_d = 1'b0;
         if (fire)
         begin
            pend_v_d   = 1'b0;
            cur_v_d    = 1'b1;                         // [RQ10]
            cur_wr_d   = pend_wr_q;
            cur_ap_d   = pend_ap_q;
            cur_bank_d = pend_bank_q;
            cur_col_d  = pend_col_q;
            cur_bl8_d  = cfg_l.bl8;
            cur_il_d   = cfg_l.interleave;
            beat_d     = 3'h0;
         end
         // read beats and their strobe leave one edge after the state
         dq_oe_d  = cur_v_q && !cur_wr_q;
         dqs_oe_d = cur_v_q && !cur_wr_q;              // [RQ2]
         dqs_d    = cur_v_q && !beat_q[0];
         dq_d     = mem_q[mem_a];
      end
      if (col_w && hit)
      begin
         pend_v_d    = 1'b1;                           // [RQ4]
         pend_wr_d   = op == OP_WR;
         pend_ap_d   = cmd_i.addr[AP_BIT];             // [RQ16]
         pend_bank_d = cmd_i.bank_select;
         pend_col_d  = cmd_i.addr[COL_W-1:0];          // [RQ16]
         pend_cnt_d  = (op == OP_RD) ? rd_lat : wr_lat; // [RQ7] [RQ8]
      end
   end

   always_ff @(posedge lnk_clk_i)
   begin
      if (rst_lnk_q)
      begin
         pend_v_q <= 1'b0;  pend_wr_q <= 1'b0;  pend_ap_q <= 1'b0;
         pend_bank_q <= '0; pend_col_q <= '0;   pend_cnt_q <= 4'h0;
         cur_v_q <= 1'b0;   cur_wr_q <= 1'b0;   cur_ap_q <= 1'b0;
         cur_bl8_q <= 1'b0; cur_il_q <= 1'b0;
         cur_bank_q <= '0;  cur_col_q <= '0;    beat_q <= 3'h0;
         dq_q <= '0; dq_oe_q <= 1'b0; dqs_q <= 1'b0; dqs_oe_q <= 1'b0;
      end
      else
      begin
         pend_v_q <= pend_v_d;   pend_wr_q <= pend_wr_d;
         pend_ap_q <= pend_ap_d; pend_bank_q <= pend_bank_d;
         pend_col_q <= pend_col_d;   pend_cnt_q <= pend_cnt_d;
         cur_v_q <= cur_v_d;     cur_wr_q <= cur_wr_d;
         cur_ap_q <= cur_ap_d;   cur_bl8_q <= cur_bl8_d;
         cur_il_q <= cur_il_d;   cur_bank_q <= cur_bank_d;
         cur_col_q <= cur_col_d; beat_q <= beat_d;
         dq_q <= dq_d;  dq_oe_q <= dq_oe_d;
         dqs_q <= dqs_d; dqs_oe_q <= dqs_oe_d;
      end
   end

   // data array is not reset: contents are undefined until written
   always_ff @(posedge lnk_clk_i)
   begin
      if (mem_we)
         mem_q[mem_a] <= dq_i;                         // [RQ2]
   end

   // outputs and status word
   assign dq_o     = dq_q;
   assign dq_oe_o  = dq_oe_q;
   assign dqs_o    = dqs_q;
   assign dqs_oe_o = dqs_oe_q;
   assign stat_l   = '{open_banks: open_q, pwr: pwr_q,
                       col_reject: rej_q, ref_count: refc_q};

   // checks
   a_act_opens: assert property (@(posedge lnk_clk_i) // [RQ15]
      disable iff (rst_lnk_q) (awake && op == OP_ACT)
      |=> open_q[$past(cmd_i.bank_select)])
      else $error("activate did not open its bank");
   a_pre_closes: assert property (@(posedge lnk_clk_i) // [RQ15]
      disable iff (rst_lnk_q) (awake && op == OP_PRE)
      |=> !open_q[$past(cmd_i.bank_select)])
      else $error("precharge did not close its bank");
   a_banks_indep: assert property (@(posedge lnk_clk_i) // [RQ9]
      disable iff (rst_lnk_q) (awake && op == OP_ACT && !ap_close)
      |=> ($past(open_q) & ~open_q) == '0)
      else $error("activate closed another bank");
   a_col_reject: assert property (@(posedge lnk_clk_i) // [RQ4]
      disable iff (rst_lnk_q) (col_w && !hit && !pend_v_q)
      |=> rej_q && !pend_v_q)
      else $error("column command to closed bank accepted");
   a_cs_ignore: assert property (@(posedge lnk_clk_i) // [RQ14]
      disable iff (rst_lnk_q) (cmd_i.cs_n && awake && !busy && !ap_close)
      |=> $stable(open_q) && !pend_v_q && $stable(refc_q))
      else $error("command taken with chip select high");
   a_rd_latency: assert property (@(posedge lnk_clk_i) // [RQ8]
      disable iff (rst_lnk_q) (col_w && hit && op == OP_RD)
      |=> pend_v_q && pend_cnt_q == $past(rd_lat))
      else $error("read latency not additive plus cas");
   a_wr_offset: assert property (@(posedge lnk_clk_i) // [RQ7]
      disable iff (rst_lnk_q) (col_w && hit && op == OP_WR)
      |=> pend_cnt_q + 4'h1 == $past(rd_lat))
      else $error("write latency not read latency minus one");
   a_burst_min: assert property (@(posedge lnk_clk_i) // [RQ5]
      disable iff (rst_lnk_q) $rose(dq_oe_o) |-> dq_oe_o [*4])
      else $error("read burst shorter than four beats");
   a_auto_pre: assert property (@(posedge lnk_clk_i) // [RQ6]
      disable iff (rst_lnk_q) (ap_close && !(awake && op == OP_ACT))
      |=> !open_q[$past(cur_bank_q)])
      else $error("auto precharge left the row open");
   a_freeze_hold: assert property (@(posedge lnk_clk_i) // [RQ17]
      disable iff (rst_lnk_q) frozen
      |=> $stable(dq_o) && $stable(beat_q) && $stable(dq_oe_o))
      else $error("outputs moved while clock enable low");
   a_pd_entry: assert property (@(posedge lnk_clk_i) // [RQ11]
      disable iff (rst_lnk_q)
      (pwr_q == PWR_ON && cke_q && !cke_i && op != OP_REF)
      |=> (pwr_q == PWR_ACT_PD) == ($past(open_q) != '0) &&
          pwr_q != PWR_ON && pwr_q != PWR_SELF_REF)
      else $error("wrong power-down state entered");
   a_self_ref: assert property (@(posedge lnk_clk_i) // [RQ12]
      disable iff (rst_lnk_q)
      (pwr_q == PWR_ON && cke_q && !cke_i && op == OP_REF &&
       open_q == '0) |=> pwr_q == PWR_SELF_REF)
      else $error("self refresh not entered");

endmodule

// >>> dv/dsa_ctrl_model.sv
module dsa_ctrl_model import dsa_pkg::*;
(
   // link clock and command pins
   input  wire logic                   lnk_clk_i,
   output dsa_pkg::dsa_cmd_t           cmd_o,
   output logic                        cke_o,
   // board-level data wires
   input  wire logic [dsa_pkg::DQ_W-1:0] dq_i,
   input  wire logic                   dqs_i,
   input  wire logic                   oe_i,
   output logic [dsa_pkg::DQ_W-1:0]    dq_o,
   output logic                        dqs_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [DQ_W-1:0] beat_q [8];
   logic [7:0]      oe_q;
   logic [7:0]      dqs_q;

   // idle: deselected, clock enabled
   initial
   begin
      cmd_o = '1;
      cke_o = 1'b1;
      dq_o  = '0;
      dqs_o = 1'b0;
   end

   // row or column on the shared bus, bank beside it
   // held over exactly one rising edge
   task automatic issue(input logic cs_n, input logic [2:0] rcw,
                        input logic [2:0] bank, input logic [12:0] addr,
                        input logic cke);
      @(posedge lnk_clk_i);
      #1;
      cmd_o = {cs_n, rcw, bank, addr};
      cke_o = cke;
      @(posedge lnk_clk_i);
      #1;
      cmd_o.cs_n = 1'b1;
   endtask

   // data launched one cycle before the read latency, strobe toggling
   // per beat bank must already be opened
   task automatic write(input logic [2:0] bank, input int wl, input int bl,
                        input logic [15:0] base);
      issue(1'b0, 3'b100, bank, 13'h0000, 1'b1);
      repeat (wl) @(posedge lnk_clk_i);
      #1;
      for (int k = 0; k < bl; k++)
      begin
         dq_o  = base + 16'(k);
         dqs_o = ~dqs_o;
         @(posedge lnk_clk_i);
         #1;
      end
      dq_o = ~dq_o; // inverted: the last beat's value does not stay on the wire
   endtask

   // read: capture eight slots from the first expected beat onwards
   task automatic read(input logic [2:0] bank, input logic [12:0] addr,
                       input int rl);
      issue(1'b0, 3'b101, bank, addr, 1'b1);
      repeat (rl + 1) @(posedge lnk_clk_i);
      for (int k = 0; k < 8; k++)
      begin
         #1;
         beat_q[k] = dq_i;
         oe_q[k]   = oe_i;
         dqs_q[k]  = dqs_i;
         @(posedge lnk_clk_i);
      end
   endtask
endmodule

// >>> dv/test_ddr2_sdram_access_core.sv
`define CHK(nm, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("unexpected %s expected %h seen %h", nm, e, g); \
      end \
   end

module test_ddr2_sdram_access_core import dsa_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic            ref_clk_i;
   logic            srst_i;
   logic            lnk_clk;
   logic            cke;
   logic            dq_oe;
   logic            dqs_oe;
   logic            dev_dqs;
   logic            ctl_dqs;
   logic [DQ_W-1:0] dev_dq;
   logic [DQ_W-1:0] ctl_dq;
   wire [DQ_W-1:0]  dq_w;
   wire             dqs_w;
   dsa_cfg_t        cfg;
   dsa_stat_t       stat;
   dsa_cmd_t        cmd;
   int              n_fail;
   int              compares;

   // wire level picked by the device's enables alone
   assign dq_w  = dq_oe ? dev_dq : ctl_dq;
   assign dqs_w = dqs_oe ? dev_dqs : ctl_dqs;

   initial
   begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   // link clock offset so no edge meets the register clock
   initial
   begin
      lnk_clk = 1'b0;
      #1.7;
      forever #3 lnk_clk = ~lnk_clk;
   end

   dsa_access_core uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .cfg_i(cfg), .stat_o(stat), .lnk_clk_i(lnk_clk), .cke_i(cke),
      .cmd_i(cmd), .dq_i(dq_w), .dq_o(dev_dq), .dq_oe_o(dq_oe),
      .dqs_i(dqs_w), .dqs_o(dev_dqs), .dqs_oe_o(dqs_oe));

   dsa_ctrl_model ctl (.lnk_clk_i(lnk_clk), .cmd_o(cmd), .cke_o(cke),
      .dq_i(dq_w), .dqs_i(dqs_w), .oe_i(dq_oe), .dq_o(ctl_dq),
      .dqs_o(ctl_dqs));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // status crosses by handshake: one round trip is three register
   // cycles, and a change may wait behind a word already in flight
   task automatic settle();
      repeat (8) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic set_cfg(input dsa_cfg_t c);
      @(posedge ref_clk_i);
      #1;
      cfg = c;
      settle();
   endtask

   // expected order worked out independently of the design
   task automatic chk_rd(input logic [15:0] base, input logic [2:0] st,
                         input int bl, input logic il);
      logic [2:0] c;
      for (int k = 0; k < bl; k++)
      begin
         c = il ? st ^ 3'(k) : (bl == 8) ? st + 3'(k)
                : {st[2], st[1:0] + 2'(k)};
         `CHK("beat", base + 16'(c), ctl.beat_q[k])
         `CHK("dq_oe", 1'b1, ctl.oe_q[k])
         `CHK("dqs", ~k[0], ctl.dqs_q[k])
      end
      if (bl < 8)
         `CHK("dq_oe_end", 1'b0, ctl.oe_q[bl])
   endtask

   // hang guard
   initial
   begin
      repeat (3000) @(posedge ref_clk_i);
      n_fail++;
      end_of_test();
   end

   initial
   begin
      n_fail   = 0;
      compares = 0;
      srst_i   = 1'b1;
      cfg      = '{1'b0, 1'b0, 3'h0, 3'h2};
      repeat (10) @(posedge ref_clk_i);
      #1;
      `CHK("open_rst", 8'h00, stat.open_banks)
      `CHK("oe_rst", 1'b0, dq_oe)
      srst_i = 1'b0;
      settle();
      ctl.issue(1'b0, 3'b011, 3'd2, 13'h1fff, 1'b1);
      ctl.issue(1'b0, 3'b011, 3'd5, 13'h0000, 1'b1);
      settle();
      `CHK("open_act", 8'h24, stat.open_banks)
      ctl.read(3'd0, 13'h0000, 2);
      settle();
      `CHK("reject", 1'b1, stat.col_reject)
      `CHK("reject_oe", 1'b0, ctl.oe_q[0])
      ctl.issue(1'b1, 3'b010, 3'd5, 13'h0000, 1'b1);
      settle();
      `CHK("masked", 8'h24, stat.open_banks)
      ctl.issue(1'b0, 3'b010, 3'd5, 13'h0000, 1'b1);
      settle();
      `CHK("pre_one", 8'h04, stat.open_banks)
      $display("test decode finished");
      ctl.write(3'd2, 1, 4, 16'h1000);
      ctl.read(3'd2, 13'h0001, 2);
      chk_rd(16'h1000, 3'h1, 4, 1'b0);
      ctl.read(3'd2, 13'h0402, 2);
      chk_rd(16'h1000, 3'h2, 4, 1'b0);
      settle();
      `CHK("auto_pre", 8'h00, stat.open_banks)
      ctl.issue(1'b0, 3'b001, 3'd0, 13'h0000, 1'b1);
      settle();
      `CHK("refresh", 4'h1, stat.ref_count)
      $display("test burst4 finished");
      set_cfg('{1'b1, 1'b1, 3'h1, 3'h3});
      ctl.issue(1'b0, 3'b011, 3'd3, 13'h0001, 1'b1);
      ctl.write(3'd3, 3, 8, 16'h2000);
      ctl.read(3'd3, 13'h0003, 4);
      chk_rd(16'h2000, 3'h3, 8, 1'b1);
      $display("test burst8 finished");
      ctl.issue(1'b1, 3'b111, 3'd0, 13'h0000, 1'b0);
      settle();
      `CHK("act_pd", PWR_ACT_PD, stat.pwr)
      ctl.issue(1'b1, 3'b111, 3'd0, 13'h0000, 1'b1);
      settle();
      `CHK("pd_exit", PWR_ON, stat.pwr)
      ctl.issue(1'b0, 3'b010, 3'd3, 13'h0000, 1'b1);
      ctl.issue(1'b1, 3'b111, 3'd0, 13'h0000, 1'b0);
      settle();
      `CHK("pre_pd", PWR_PRE_PD, stat.pwr)
      ctl.issue(1'b1, 3'b111, 3'd0, 13'h0000, 1'b1);
      // case temperature taken as inside the self refresh range
      ctl.issue(1'b0, 3'b001, 3'd0, 13'h0000, 1'b0);
      settle();
      `CHK("self_ref", PWR_SELF_REF, stat.pwr)
      ctl.issue(1'b1, 3'b111, 3'd0, 13'h0000, 1'b1);
      settle();
      `CHK("sr_exit", PWR_ON, stat.pwr)
      $display("test power finished");
      end_of_test();
   end
endmodule
